// [design/pp_comm_pkg.sv]
package pp_comm_pkg;

  // ----------------------------------------------------------------
  // clocking and derived counts
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ          = 20_000_000;
  localparam int TIMER_HZ          = 10_000_000;
  localparam int TIMER_TICK_CYCLES = (CLOCK_HZ + TIMER_HZ - 1) / TIMER_HZ;
  localparam int TONE_HZ           = 1000;
  localparam int TONE_HALF_CYCLES  = CLOCK_HZ / (2 * TONE_HZ);

  // ----------------------------------------------------------------
  // register indices, byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_COMMAND      = 6'h00;
  localparam logic [5:0] IDX_PRIORITY     = 6'h01;
  localparam logic [5:0] IDX_STARTUP      = 6'h02;
  localparam logic [5:0] IDX_ELAPSED_LO   = 6'h03;
  localparam logic [5:0] IDX_ELAPSED_HI   = 6'h04;
  localparam logic [5:0] IDX_AVAIL        = 6'h05;
  localparam logic [5:0] IDX_COND         = 6'h06;
  localparam logic [5:0] IDX_PROTECT      = 6'h07;
  localparam logic [5:0] CR_PROTECT_LIMIT = 6'h13;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int XFER_BIT     = 16;
  localparam int SU_START     = 0;
  localparam int SU_BOOT      = 1;
  localparam int SU_DISC      = 2;
  localparam int SU_OPER      = 3;
  localparam int SU_RATE_LO   = 4;
  localparam int SU_TONE_MODE = 6;
  localparam int SU_ALARM     = 7;
  localparam int COND_DONE    = 7;
  localparam int ADDR_W       = 24;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RATE_NOMINAL = 2'h0;
  localparam logic [1:0]  CLASS_WRITE  = 2'h0;
  localparam logic [1:0]  CLASS_OPER   = 2'h2;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

endpackage

// [design/arb_if.sv]
`timescale 1ns/1ps
interface arb_if;
  logic [7:0] req;
  logic [7:0] prio;
  logic       ready;
  logic       grant_valid;
  logic [2:0] grant_vp;
  modport arbiter (input req, prio, ready, output grant_valid, grant_vp);
  modport client  (output req, prio, ready, input grant_valid, grant_vp);
endinterface

// [design/mem_request_arbiter.sv]
`timescale 1ns/1ps
module mem_request_arbiter (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // request side
  arb_if.arbiter   port
);

  typedef struct packed {
    logic [7:0]       pending;
    logic [7:0][3:0]  age;
    logic             grant_valid;
    logic [2:0]       grant_vp;
    logic             gprio;
  } arb_t;

  arb_t st;
  arb_t next_st;

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] best;
    logic       found;
    best = 3'h0;
    found = 1'b0;
    next_st = st;
    next_st.grant_valid = 1'b0;
    // then oldest; ages saturate, so very old ties fall back to index order
    for (int i = 0; i < 8; i++) begin
      if (st.pending[i]) begin
        if (!found || (port.prio[i] < port.prio[best]) ||
            (port.prio[i] == port.prio[best] && st.age[i] > st.age[best])) begin
          best = 3'(i);
          found = 1'b1;
        end
      end
      if (st.pending[i] && st.age[i] != 4'hf) begin
        next_st.age[i] = st.age[i] + 4'h1;
      end
    end
    if (found && port.ready) begin
      next_st.grant_valid = 1'b1;
      next_st.grant_vp = best;
      next_st.gprio = port.prio[best];
      next_st.pending[best] = 1'b0;
    end
    // a new request wins over the grant that clears it
    for (int i = 0; i < 8; i++) begin
      if (port.req[i]) begin
        next_st.pending[i] = 1'b1;
        next_st.age[i] = 4'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.grant_valid = st.grant_valid;
  assign port.grant_vp = st.grant_vp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_grant_high_first: assert property (@(posedge clock) disable iff (!arst_n)
    (port.ready && |(st.pending & ~port.prio)) |=> (st.grant_valid && !st.gprio))
    else $error("low priority request granted over high");
  a_grant_oldest: assert property (@(posedge clock) disable iff (!arst_n)
    (port.ready && st.pending == 8'h03 && port.prio[1:0] == 2'h0 && st.age[1] > st.age[0])
    |=> (st.grant_valid && st.grant_vp == 3'h1))
    else $error("older request not granted first");
  c_grant_tie: cover property (@(posedge clock) disable iff (!arst_n)
    port.ready && st.pending[0] && st.pending[1] && port.prio[0] == port.prio[1]);

endmodule

// [design/pp_comm_register_ctrl.sv]
`timescale 1ns/1ps
module pp_comm_register_ctrl #(
  parameter int TONE_HALF = pp_comm_pkg::TONE_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [2:0]  reg_vp,
  output logic      [31:0] reg_rdata,
  // maintenance command
  input  wire logic [2:0]  unit_xfer_clear,
  output logic      [15:0] maint_command,
  output logic             maint_xfer,
  // unit condition events
  input  wire logic [7:0]  dcu_event,
  input  wire logic [7:0]  cp_event,
  input  wire logic [7:0]  mcu_event,
  // panels
  input  wire logic        start_btn,
  input  wire logic        load_btn,
  input  wire logic        init_switch_held,
  input  wire logic        init_switch_disc,
  input  wire logic        clock_rate_normal,
  input  wire logic        test_mode_normal,
  input  wire logic [2:0]  processor_select_switch,
  output logic             operating_lamp,
  output logic             alarm_out,
  output logic      [1:0]  clock_rate_sel,
  // time slot
  input  wire logic [2:0]  slot_vp,
  output logic             slot_priority,
  output logic             slot_cr_protect,
  output logic             slot_cm_protect,
  output logic             slot_override,
  // central memory requests
  input  wire logic [7:0]  mem_req,
  input  wire logic        mem_ready,
  output logic             mem_grant_valid,
  output logic      [2:0]  mem_grant_vp,
  input  wire logic        cm_chk_valid,
  input  wire logic [2:0]  cm_chk_vp,
  input  wire logic [1:0]  cm_chk_class,
  input  wire logic [23:0] cm_chk_addr,
  input  wire logic [71:0] cm_bound_lo,
  input  wire logic [71:0] cm_bound_hi,
  output logic             cm_write_suppress,
  output logic             vp_interrupt
);

  typedef struct packed {
    logic [15:0] command;
    logic        xfer;
    logic [15:0] priority_bits;
    logic [7:0]  startup;
    logic [39:0] timer;
    logic [3:0]  timer_div;
    logic [39:0] elapsed;
    logic [7:0]  avail;
    logic [7:0]  dcu_cond;
    logic [7:0]  cp_cond;
    logic [7:0]  mcu_cond;
    logic [7:0]  cr_prot;
    logic [7:0]  cm_prot;
    logic [31:0] rdata;
    logic        slot_prio;
    logic        slot_crp;
    logic        slot_cmp;
    logic        override;
    logic        interrupt;
    logic        suppress;
    logic [1:0]  rate;
    logic [15:0] tone_cnt;
    logic        tone;
    logic        alarm;
  } regs_t;

  regs_t st;
  regs_t next_st;

  // ----------------------------------------------------------------
  // request arbiter
  // ----------------------------------------------------------------
  arb_if arb ();
  assign arb.req = mem_req;
  assign arb.prio = st.priority_bits[7:0];
  assign arb.ready = mem_ready;

  mem_request_arbiter u_arbiter (
    .clock  (clock),
    .arst_n (arst_n),
    .port   (arb.arbiter)
  );

  assign mem_grant_valid = arb.grant_valid;
  assign mem_grant_vp = arb.grant_vp;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic [5:0]  idx;
  logic        load_valid;
  logic        startup_req;
  logic        wr_exempt;
  logic        wr_blocked;
  logic        wr_ok;
  logic [1:0]  bsel;
  logic [23:0] lo;
  logic [23:0] hi;
  logic        cm_viol;

  assign idx = reg_addr[7:2];
  assign load_valid = load_btn && init_switch_held;
  assign startup_req = start_btn || load_valid;
  assign wr_exempt = test_mode_normal && (reg_vp == processor_select_switch);
  assign wr_blocked = reg_wr && st.cr_prot[reg_vp] && !wr_exempt && (idx <= pp_comm_pkg::CR_PROTECT_LIMIT);
  assign wr_ok = reg_wr && !wr_blocked;
  assign bsel = (cm_chk_class > pp_comm_pkg::CLASS_OPER) ? pp_comm_pkg::CLASS_OPER : cm_chk_class;
  assign lo = cm_bound_lo[bsel * pp_comm_pkg::ADDR_W +: pp_comm_pkg::ADDR_W];
  assign hi = cm_bound_hi[bsel * pp_comm_pkg::ADDR_W +: pp_comm_pkg::ADDR_W];
  assign cm_viol = cm_chk_valid && st.cm_prot[cm_chk_vp] && (cm_chk_addr < lo || cm_chk_addr > hi);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = pp_comm_pkg::RESET_WORD;
    // software writes
    if (wr_ok) begin
      case (idx)
        pp_comm_pkg::IDX_COMMAND: begin
          next_st.command = reg_wdata[15:0];
          next_st.xfer = reg_wdata[pp_comm_pkg::XFER_BIT];
        end
        pp_comm_pkg::IDX_PRIORITY: next_st.priority_bits = reg_wdata[15:0];
        pp_comm_pkg::IDX_STARTUP: next_st.startup = reg_wdata[7:0];
        pp_comm_pkg::IDX_AVAIL: next_st.avail = reg_wdata[7:0];
        pp_comm_pkg::IDX_PROTECT: begin
          next_st.cr_prot = reg_wdata[7:0];
          next_st.cm_prot = reg_wdata[15:8];
        end
        pp_comm_pkg::IDX_COND: begin
          next_st.dcu_cond = st.dcu_cond & ~reg_wdata[7:0];
          next_st.cp_cond = st.cp_cond & ~reg_wdata[15:8];
          next_st.mcu_cond = st.mcu_cond & ~reg_wdata[23:16];
        end
        default: ;
      endcase
    end
    // clear comes from any unit's bit of unit_xfer_clear; a software set in the same cycle wins
    if (|unit_xfer_clear && !(wr_ok && idx == pp_comm_pkg::IDX_COMMAND && reg_wdata[pp_comm_pkg::XFER_BIT])) begin
      next_st.xfer = 1'b0;
    end
    // unit event sets, wins over clear
    next_st.dcu_cond = next_st.dcu_cond | dcu_event;
    next_st.cp_cond = next_st.cp_cond | cp_event;
    next_st.mcu_cond = next_st.mcu_cond | mcu_event;
    if (startup_req) begin
      next_st.startup[pp_comm_pkg::SU_START] = 1'b1;
      next_st.startup[pp_comm_pkg::SU_OPER] = 1'b1;
    end
    if (load_valid) begin
      next_st.startup[pp_comm_pkg::SU_BOOT] = 1'b1;
      next_st.startup[pp_comm_pkg::SU_DISC] = init_switch_disc;
    end
    if (st.timer_div == 4'(pp_comm_pkg::TIMER_TICK_CYCLES - 1)) begin
      next_st.timer_div = 4'h0;
      next_st.timer = st.timer + 40'h00_0000_0001;
    end else begin
      next_st.timer_div = st.timer_div + 4'h1;
    end
    // copy refreshed every cycle, so writes never stick
    next_st.elapsed = st.timer;
    next_st.slot_prio = st.priority_bits[slot_vp];
    next_st.slot_crp = st.cr_prot[slot_vp];
    next_st.slot_cmp = st.cm_prot[slot_vp];
    next_st.suppress = cm_viol && (cm_chk_class == pp_comm_pkg::CLASS_WRITE);
    next_st.interrupt = cm_viol && (cm_chk_vp == processor_select_switch);
    next_st.override = wr_blocked || (cm_viol && (cm_chk_vp != processor_select_switch));
    if (clock_rate_normal && (st.startup[5:4] == 2'h1 || st.startup[5:4] == 2'h2)) begin
      // bit 4 is the code's first digit, so the pair is swapped onto the output
      next_st.rate = {st.startup[pp_comm_pkg::SU_RATE_LO], st.startup[pp_comm_pkg::SU_RATE_LO + 1]};
    end else begin
      next_st.rate = pp_comm_pkg::RATE_NOMINAL;
    end
    // fixed tone divider; its period is a parameter so benches can shorten it
    if (st.tone_cnt >= 16'(TONE_HALF - 1)) begin
      next_st.tone_cnt = 16'h0000;
      next_st.tone = !st.tone;
    end else begin
      next_st.tone_cnt = st.tone_cnt + 16'h0001;
    end
    if (st.startup[pp_comm_pkg::SU_TONE_MODE]) begin
      next_st.alarm = st.startup[pp_comm_pkg::SU_ALARM] && st.tone;
    end else begin
      next_st.alarm = st.startup[pp_comm_pkg::SU_ALARM];
    end
    // read data, unmapped reads zero
    if (reg_rd) begin
      case (idx)
        pp_comm_pkg::IDX_COMMAND:    next_st.rdata = {15'h0000, st.xfer, st.command};
        pp_comm_pkg::IDX_PRIORITY:   next_st.rdata = {16'h0000, st.priority_bits};
        pp_comm_pkg::IDX_STARTUP:    next_st.rdata = {24'h00_0000, st.startup};
        pp_comm_pkg::IDX_ELAPSED_LO: next_st.rdata = st.elapsed[31:0];
        pp_comm_pkg::IDX_ELAPSED_HI: next_st.rdata = {24'h00_0000, st.elapsed[39:32]};
        pp_comm_pkg::IDX_AVAIL:      next_st.rdata = {24'h00_0000, st.avail};
        pp_comm_pkg::IDX_COND:       next_st.rdata = {8'h00, st.mcu_cond, st.cp_cond, st.dcu_cond};
        pp_comm_pkg::IDX_PROTECT:    next_st.rdata = {16'h0000, st.cm_prot, st.cr_prot};
        default:                     next_st.rdata = pp_comm_pkg::RESET_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // all cells cleared by reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign maint_command = st.command;
  assign maint_xfer = st.xfer;
  assign operating_lamp = st.startup[pp_comm_pkg::SU_OPER];
  assign alarm_out = st.alarm;
  assign clock_rate_sel = st.rate;
  assign slot_priority = st.slot_prio;
  assign slot_cr_protect = st.slot_crp;
  assign slot_cm_protect = st.slot_cmp;
  assign slot_override = st.override;
  assign cm_write_suppress = st.suppress;
  assign vp_interrupt = st.interrupt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_xfer_unit_clear: assert property (
    (|unit_xfer_clear && !reg_wr) |=> !maint_xfer)
    else $error("transfer flag not cleared by unit");
  a_xfer_set_wins: assert property (
    (wr_ok && idx == pp_comm_pkg::IDX_COMMAND && reg_wdata[pp_comm_pkg::XFER_BIT]) |=> maint_xfer)
    else $error("software transfer set lost");
  a_slot_prio_pick: assert property (
    1'b1 |=> slot_priority == $past(st.priority_bits[slot_vp]))
    else $error("slot priority does not follow owner");
  a_start_flags: assert property (
    startup_req |=> (st.startup[0] && st.startup[3] && operating_lamp))
    else $error("start-up flags not set");
  a_load_device: assert property (
    load_valid |=> (st.startup[1] && st.startup[2] == $past(init_switch_disc)))
    else $error("load start-up flags wrong");
  a_load_needs_switch: assert property (
    (load_btn && !init_switch_held && !start_btn && !reg_wr) |=> $stable(st.startup))
    else $error("load accepted without switch");
  a_alarm_fixed_off: assert property (
    (st.startup[6] && !st.startup[7]) |=> !alarm_out)
    else $error("fixed tone sounding while off");
  a_alarm_direct: assert property (
    !st.startup[6] |=> alarm_out == $past(st.startup[7]))
    else $error("generated mode not following bit");
  a_rate_ignored: assert property (
    !clock_rate_normal |=> clock_rate_sel == 2'h0)
    else $error("clock bits applied off normal");
  a_elapsed_copy: assert property (
    1'b1 |=> st.elapsed == $past(st.timer))
    else $error("elapsed copy not refreshed");
  a_cond_msb_set: assert property (
    cp_event[7] |=> st.cp_cond[7])
    else $error("command complete lost");
  a_cond_sw_clear: assert property (
    (wr_ok && idx == pp_comm_pkg::IDX_COND && reg_wdata[15] && !cp_event[7]) |=> !st.cp_cond[7])
    else $error("command complete not cleared");
  a_cr_block: assert property (
    wr_blocked |=> (slot_override && $stable(st.avail) && $stable(st.priority_bits)))
    else $error("protected write not blocked");
  a_cm_suppress: assert property (
    (cm_viol && cm_chk_class == 2'h0) |=> (cm_write_suppress && (vp_interrupt != slot_override)))
    else $error("memory violation not handled");

  c_load_start: cover property (load_valid ##1 operating_lamp);
  c_cr_violation: cover property (wr_blocked);
  c_cm_violation: cover property (cm_viol ##1 vp_interrupt);

endmodule

// [dv/unit_partner.sv]
`timescale 1ns/1ps
// far side units: take commands, drop the flag, report completion
module unit_partner #(
  parameter int DELAY = 3
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // command side
  input  wire logic [15:0] maint_command,
  input  wire logic        maint_xfer,
  input  wire logic        raise_parity,
  output logic      [2:0]  unit_xfer_clear,
  output logic      [7:0]  dcu_event,
  output logic      [7:0]  cp_event,
  output logic      [7:0]  mcu_event
);
  int         wait_cnt;
  logic [1:0] unit_id;
  logic       fire;
  assign unit_id = maint_command[15:14];
  // guard on the clear pulse: the flag only drops one cycle after it
  assign fire    = maint_xfer && (unit_xfer_clear == 3'h0) && (wait_cnt == DELAY);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt        <= 0;
      unit_xfer_clear <= 3'h0;
      dcu_event       <= 8'h00;
      cp_event        <= 8'h00;
      mcu_event       <= 8'h00;
    end else begin
      unit_xfer_clear <= fire ? (3'h1 << unit_id) : 3'h0;
      if (maint_xfer && (unit_xfer_clear == 3'h0)) begin
        wait_cnt <= fire ? 0 : wait_cnt + 1;
      end
      dcu_event <= {fire && (unit_id == 2'h0), 7'h00};
      mcu_event <= {fire && (unit_id == 2'h2), 7'h00};
      cp_event  <= {fire && (unit_id == 2'h1), 6'h00, raise_parity};
    end
  end
endmodule

// [dv/pp_comm_register_ctrl_test.sv]
`timescale 1ns/1ps
module pp_comm_register_ctrl_test;
  logic clock, arst_n, reg_wr, reg_rd, start_btn, load_btn, init_switch_held, init_switch_disc;
  logic clock_rate_normal, test_mode_normal, mem_ready, cm_chk_valid, raise_parity;
  logic operating_lamp, alarm_out, maint_xfer, slot_priority, slot_cr_protect, slot_cm_protect;
  logic slot_override, mem_grant_valid, cm_write_suppress, vp_interrupt;
  logic [7:0] reg_addr, mem_req, dcu_event, cp_event, mcu_event;
  logic [2:0] reg_vp, unit_xfer_clear, processor_select_switch, slot_vp, mem_grant_vp, cm_chk_vp;
  logic [1:0] clock_rate_sel, cm_chk_class;
  logic [31:0] reg_wdata, reg_rdata, v, w;
  logic [15:0] maint_command;
  logic [23:0] cm_chk_addr;
  logic [71:0] cm_bound_lo, cm_bound_hi;
  logic [2:0] grants[$];
  int failures, samples_checked, cycles, ovr_cnt, int_cnt, sup_cnt, tog;

  pp_comm_register_ctrl #(.TONE_HALF(4)) u_pp_comm_register_ctrl (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_vp(reg_vp),
    .reg_rdata(reg_rdata), .unit_xfer_clear(unit_xfer_clear), .maint_command(maint_command),
    .maint_xfer(maint_xfer), .dcu_event(dcu_event), .cp_event(cp_event), .mcu_event(mcu_event),
    .start_btn(start_btn), .load_btn(load_btn), .init_switch_held(init_switch_held),
    .init_switch_disc(init_switch_disc), .clock_rate_normal(clock_rate_normal),
    .test_mode_normal(test_mode_normal), .processor_select_switch(processor_select_switch),
    .operating_lamp(operating_lamp), .alarm_out(alarm_out), .clock_rate_sel(clock_rate_sel),
    .slot_vp(slot_vp), .slot_priority(slot_priority), .slot_cr_protect(slot_cr_protect),
    .slot_cm_protect(slot_cm_protect), .slot_override(slot_override), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_grant_valid(mem_grant_valid), .mem_grant_vp(mem_grant_vp),
    .cm_chk_valid(cm_chk_valid), .cm_chk_vp(cm_chk_vp), .cm_chk_class(cm_chk_class),
    .cm_chk_addr(cm_chk_addr), .cm_bound_lo(cm_bound_lo), .cm_bound_hi(cm_bound_hi),
    .cm_write_suppress(cm_write_suppress), .vp_interrupt(vp_interrupt));

  unit_partner u_unit_partner (.clock(clock), .arst_n(arst_n), .maint_command(maint_command),
    .maint_xfer(maint_xfer), .raise_parity(raise_parity), .unit_xfer_clear(unit_xfer_clear),
    .dcu_event(dcu_event), .cp_event(cp_event), .mcu_event(mcu_event));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  task automatic cm_check(input logic [2:0] vp, input logic [1:0] cls, input logic [23:0] a);
    @(posedge clock);
    cm_chk_valid <= 1'b1; cm_chk_vp <= vp; cm_chk_class <= cls; cm_chk_addr <= a;
    @(posedge clock);
    cm_chk_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // pulse counters; a hang ends the run through the same report
  always @(posedge clock) begin
    if (mem_grant_valid === 1'b1) grants.push_back(mem_grant_vp);
    if (slot_override === 1'b1) ovr_cnt++;
    if (vp_interrupt === 1'b1) int_cnt++;
    if (cm_write_suppress === 1'b1) sup_cnt++;
    cycles++;
    if (cycles == 6000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    {arst_n, reg_wr, reg_rd, start_btn, load_btn, init_switch_held, init_switch_disc} = 7'h00;
    {clock_rate_normal, test_mode_normal, mem_ready, cm_chk_valid, raise_parity} = 5'h00;
    {reg_addr, mem_req, reg_wdata} = 48'h0;
    {reg_vp, processor_select_switch, slot_vp, cm_chk_vp, cm_chk_class, cm_chk_addr} = 38'h0;
    cm_bound_lo = {24'h00_0000, 24'h00_0200, 24'h00_0100};
    cm_bound_hi = {24'h00_00FF, 24'h00_02FF, 24'h00_01FF};
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(8'h08, v); check(v, 40'h0);
    rd(8'hFC, v); check(v, 40'h0);
    // command word, partner clears flag, cp reports completion
    wr(8'h00, 32'h0001_4234);
    @(negedge clock); check({maint_xfer, maint_command}, 40'h1_4234);
    v = 32'h0001_0000;
    for (int i = 0; i < 20 && v[16] !== 1'b0; i++) rd(8'h00, v);
    check(v, 40'h0000_4234);
    rd(8'h18, v); check(v, 40'h0000_8000);
    wr(8'h18, 32'h0000_8000); rd(8'h18, v); check(v, 40'h0);
    @(posedge clock) raise_parity <= 1'b1;
    @(posedge clock) raise_parity <= 1'b0;
    rd(8'h18, v); check(v, 40'h0000_0100);
    $display("test command done");
    // start-up flags
    @(posedge clock) start_btn <= 1'b1;
    @(posedge clock) start_btn <= 1'b0;
    rd(8'h08, v); check(v, 40'h09);
    check(operating_lamp, 40'h1);
    wr(8'h08, 32'h0); @(negedge clock); @(negedge clock); check(operating_lamp, 40'h0);
    @(posedge clock) load_btn <= 1'b1;
    @(posedge clock) load_btn <= 1'b0;
    rd(8'h08, v); check(v, 40'h0);
    for (int d = 1; d >= 0; d--) begin
      wr(8'h08, 32'h0);
      @(posedge clock) begin load_btn <= 1'b1; init_switch_held <= 1'b1; init_switch_disc <= d[0]; end
      @(posedge clock) begin load_btn <= 1'b0; init_switch_held <= 1'b0; end
      rd(8'h08, v); check(v, d ? 40'h0F : 40'h0B);
    end
    $display("test startup done");
    // alarm modes
    wr(8'h08, 32'h80); repeat (2) @(negedge clock); check(alarm_out, 40'h1);
    wr(8'h08, 32'h00); repeat (2) @(negedge clock); check(alarm_out, 40'h0);
    wr(8'h08, 32'hC0); tog = 0; @(negedge clock) w[0] = alarm_out;
    repeat (24) begin @(negedge clock); if (alarm_out !== w[0]) tog++; w[0] = alarm_out; end
    check(tog >= 5 && tog <= 7, 40'h1);
    wr(8'h08, 32'h40); @(negedge clock); tog = 0;
    repeat (12) begin @(negedge clock); if (alarm_out !== 1'b0) tog++; end
    check(tog, 40'h0);
    // clock rate codes with the switch normal and not
    for (int n = 0; n < 2; n++) for (int c = 0; c < 4; c++) begin
      @(posedge clock) clock_rate_normal <= n[0];
      wr(8'h08, c << 4); repeat (2) @(negedge clock);
      check(clock_rate_sel, (n == 1 && (c == 1 || c == 2)) ? 3 - c : 0);
    end
    $display("test alarm and rate done");
    // elapsed count advances at half the clock rate, writes lost
    rd(8'h0C, v); repeat (20) @(posedge clock); rd(8'h0C, w);
    check((w - v) >= 10 && (w - v) <= 12, 40'h1);
    rd(8'h10, w); check(w, 40'h0);
    wr(8'h0C, 32'hFFFF_FFFF); rd(8'h0C, w); check(w < 32'h0000_1000, 40'h1);
    $display("test elapsed done");
    // arbitration: priority then age, slot owner bit
    wr(8'h04, 32'h0000_0001); grants = {};
    @(posedge clock) mem_req <= 8'h03;
    @(posedge clock) mem_req <= 8'h08;
    @(posedge clock) mem_req <= 8'h04;
    @(posedge clock) mem_req <= 8'h00;
    repeat (3) @(posedge clock); mem_ready <= 1'b1;
    repeat (8) @(posedge clock); mem_ready <= 1'b0;
    check(grants.size(), 40'h4);
    for (int i = 0; i < 4 && i < grants.size(); i++) check(grants[i], i == 0 ? 1 : (i == 1 ? 3 : (i == 2 ? 2 : 0)));
    for (int s = 0; s < 2; s++) begin
      @(posedge clock) slot_vp <= s;
      repeat (2) @(negedge clock); check(slot_priority, s == 0);
    end
    $display("test arbitration done");
    // register write protection
    wr(8'h1C, 32'h0000_0202); ovr_cnt = 0;
    @(posedge clock) begin reg_vp <= 3'h1; slot_vp <= 3'h1; processor_select_switch <= 3'h1; end
    wr(8'h14, 32'h0000_00AA); rd(8'h14, v); check(v, 40'h0);
    check(ovr_cnt, 40'h1);
    check({slot_cr_protect, slot_cm_protect}, 40'h3);
    @(posedge clock) test_mode_normal <= 1'b1;
    wr(8'h14, 32'h0000_00AA); rd(8'h14, v); check(v, 40'hAA);
    check(ovr_cnt, 40'h1);
    $display("test protect done");
    // memory protection by class
    ovr_cnt = 0; int_cnt = 0; sup_cnt = 0;
    cm_check(3'h1, 2'h0, 24'h00_0200); check({sup_cnt, int_cnt}, 40'h1_0000_0001);
    cm_check(3'h1, 2'h2, 24'h00_0150); check({sup_cnt, int_cnt}, 40'h1_0000_0002);
    @(posedge clock) processor_select_switch <= 3'h2;
    cm_check(3'h1, 2'h1, 24'h00_0300); check(ovr_cnt, 40'h1);
    cm_check(3'h1, 2'h0, 24'h00_0150); cm_check(3'h0, 2'h0, 24'h00_0300);
    cm_check(3'h1, 2'h1, 24'h00_0250);
    check({sup_cnt, ovr_cnt}, 40'h1_0000_0001);
    cm_check(3'h1, 2'h3, 24'h00_0150);
    check(ovr_cnt, 40'h2);
    $display("test memory protect done");
    conclude();
  end
endmodule
